// ### rtl/timer_pkg.sv
// Constants for the sixteen-bit timer/counter block
package timer_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_COUNT_LOW = 5'h04;
  localparam logic [4:0] ADDR_COUNT_HIGH = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int BIT_RUN = 0;
  localparam int BIT_SOURCE = 1;
  localparam int BIT_ASYNC = 2;
  localparam int BIT_OSC_EN = 3;
  localparam int BIT_DIV_LO = 4;
  localparam int BIT_DIV_HI = 5;
  localparam int BIT_SYSCLK = 6;
  localparam int BIT_WIDE = 7;
  localparam int BIT_OVERFLOW = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hBF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCKS_PER_INSTR = 4;
  localparam logic [1:0] INSTR_LAST = 2'(CLOCKS_PER_INSTR - 1);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {REG_CONTROL, REG_LOW, REG_HIGH, REG_STATUS, REG_MASK, REG_NONE} reg_sel_type;
endpackage

// ### rtl/sixteen_bit_counter.sv
// Sixteen-bit timer/counter with AXI4-Lite register access
module sixteen_bit_counter
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic externalCountInput,
  input wire logic oscInputPin,
  input wire logic sysclkFromOscIn,
  input wire logic [1:0] portCDirection,
  input wire logic [1:0] oscPinLevel,
  output logic oscOutputPin,
  output logic oscOutputEnable,
  output logic [1:0] pinDirectionOut,
  output logic [1:0] pinReadValue,
  output logic irq
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic reg_sel_type decodeAddr(input logic [4:0] addr);
    if (addr == ADDR_CONTROL) begin
      return REG_CONTROL;
    end else if (addr == ADDR_COUNT_LOW) begin
      return REG_LOW;
    end else if (addr == ADDR_COUNT_HIGH) begin
      return REG_HIGH;
    end else if (addr == ADDR_IRQ_STATUS) begin
      return REG_STATUS;
    end else if (addr == ADDR_IRQ_MASK) begin
      return REG_MASK;
    end else begin
      return REG_NONE;
    end
  endfunction

  logic [7:0] control_reg;
  logic [15:0] count_reg;
  logic [7:0] highBuffer_reg;
  logic [2:0] divCount_reg;
  logic [1:0] instrCount_reg;
  logic status_reg;
  logic mask_reg;
  logic [4:0] syncA_reg;
  logic [4:0] syncB_reg;
  logic edgeSeen_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [4:0] awAddr_reg;
  logic [7:0] wByte_reg;
  logic wLane_reg;

  // ----------------------------------------------------------------
  // Input synchronizers
  // ----------------------------------------------------------------
  // Bits: 0 external pin, 1 oscillator, 2 sysclk status, 4:3 pin levels
  wire [4:0] rawIn = {oscPinLevel, sysclkFromOscIn, oscInputPin, externalCountInput};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_reg <= 5'h00;
      syncB_reg <= 5'h00;
    end else begin
      syncA_reg <= rawIn;
      syncB_reg <= syncA_reg;
    end
  end

  wire runEnable = control_reg[BIT_RUN];
  wire sourceExternal = control_reg[BIT_SOURCE];
  wire oscEnable = control_reg[BIT_OSC_EN];
  wire wideMode = control_reg[BIT_WIDE];
  wire [1:0] divSelect = control_reg[BIT_DIV_HI:BIT_DIV_LO];

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  // Oscillator replaces the pin as the external source when enabled
  wire extLevel = oscEnable ? syncB_reg[1] : syncB_reg[0];
  // One clock only: both sync settings see the synchronized edge
  wire extEdge = extLevel && !edgeSeen_reg;
  wire instrTick = (instrCount_reg == INSTR_LAST);
  wire rawTick = sourceExternal ? extEdge : instrTick;
  wire [2:0] divLast = 3'((4'h1 << divSelect) - 4'h1);
  wire divTick = runEnable && rawTick && (divCount_reg == divLast);
  // Ratio change keeps the old divider count
  // A low write realigns it before counting resumes

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edgeSeen_reg <= 1'b0;
      instrCount_reg <= 2'h0;
    end else begin
      edgeSeen_reg <= extLevel;
      instrCount_reg <= instrCount_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------------------------------
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire doWrite = awHeld_reg && wHeld_reg && !bvalid;
  reg_sel_type wrSel;
  assign wrSel = decodeAddr(awAddr_reg);
  wire wrLane = wLane_reg;
  wire writeCtrl = doWrite && wrLane && (wrSel == REG_CONTROL);
  wire writeLow = doWrite && wrLane && (wrSel == REG_LOW);
  wire writeHigh = doWrite && wrLane && (wrSel == REG_HIGH);
  wire writeStatus = doWrite && wrLane && (wrSel == REG_STATUS);
  wire writeMask = doWrite && wrLane && (wrSel == REG_MASK);
  wire countWrite = writeLow || (writeHigh && !wideMode);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 5'h00;
      wByte_reg <= 8'h00;
      wLane_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awTake) begin
        awAddr_reg <= awaddr;
        awHeld_reg <= 1'b1;
        awready <= 1'b0;
      end
      if (wTake) begin
        wByte_reg <= wdata[7:0];
        wLane_reg <= wstrb[0];
        wHeld_reg <= 1'b1;
        wready <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= (wrSel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read side
  // ----------------------------------------------------------------
  wire arTake = arvalid && arready;
  reg_sel_type rdSel;
  assign rdSel = decodeAddr(araddr);
  wire readLow = arTake && (rdSel == REG_LOW);
  // Status bit is live, never stored by a write
  wire [7:0] controlView = {control_reg[7], syncB_reg[2], control_reg[5:0]};
  wire [7:0] highView = wideMode ? highBuffer_reg : count_reg[15:8];
  wire [7:0] rdByte = (rdSel == REG_CONTROL) ? controlView :
                      (rdSel == REG_LOW) ? count_reg[7:0] :
                      (rdSel == REG_HIGH) ? highView :
                      (rdSel == REG_STATUS) ? {7'h00, status_reg} :
                      (rdSel == REG_MASK) ? {7'h00, mask_reg} : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (arTake) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rdByte};
      rresp <= (rdSel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control, count, buffer and divider
  // ----------------------------------------------------------------
  wire countInc = divTick && !countWrite;
  wire wrapEvent = countInc && (count_reg == COUNT_MAX);
  wire [15:0] countLoad = wideMode ? {highBuffer_reg, wByte_reg} :
                          {count_reg[15:8], wByte_reg};
  wire [15:0] count_next = writeLow ? countLoad :
                           (writeHigh && !wideMode) ? {wByte_reg, count_reg[7:0]} :
                           countInc ? count_reg + 16'h0001 : count_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_reg <= CONTROL_RESET;
      count_reg <= COUNT_RESET;
      highBuffer_reg <= 8'h00;
      divCount_reg <= 3'h0;
    end else begin
      if (writeCtrl) begin
        control_reg <= wByte_reg & CONTROL_WRITE_MASK;
      end
      count_reg <= count_next; // Software write beats an increment
      if (writeHigh && wideMode) begin
        highBuffer_reg <= wByte_reg;
      end else if (readLow && wideMode) begin
        highBuffer_reg <= count_reg[15:8];
      end
      if (writeLow) begin
        divCount_reg <= 3'h0;
      end else if (runEnable && rawTick) begin
        divCount_reg <= divTick ? 3'h0 : divCount_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= 1'b0;
      mask_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      // Wrap in the clearing cycle still sets the flag
      status_reg <= wrapEvent || (status_reg && !(writeStatus && wByte_reg[BIT_OVERFLOW]));
      if (writeMask) begin
        mask_reg <= wByte_reg[BIT_OVERFLOW];
      end
      irq <= status_reg && mask_reg;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator and pin control
  // ----------------------------------------------------------------
  // No power-mode input exists; only the run bit drops the output enable of an enabled oscillator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oscOutputPin <= 1'b0;
      oscOutputEnable <= 1'b0;
      pinDirectionOut <= 2'h3;
      pinReadValue <= 2'h0;
    end else begin
      oscOutputPin <= oscEnable && !syncB_reg[1];
      oscOutputEnable <= oscEnable && !runEnable;
      pinDirectionOut <= runEnable ? 2'h3 : portCDirection;
      pinReadValue <= runEnable ? 2'h0 : syncB_reg[4:3];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence wideLowWriteSeq;
    writeLow && wideMode;
  endsequence

  sequence extRiseSeq;
    !extLevel ##1 extLevel;
  endsequence

  sequence statusClearSeq;
    writeStatus && wByte_reg[BIT_OVERFLOW] && !wrapEvent;
  endsequence

  a_hold_stopped: assert property (!runEnable && !countWrite |=> $stable(count_reg))
    else $error("count moved while stopped");
  a_instr_rate: assert property (instrTick |=> !instrTick [*3] ##1 instrTick)
    else $error("instruction tick not every four clocks");
  a_inc_step: assert property (countInc |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not step by one");
  a_div_ratio: assert property (runEnable && rawTick && !divTick && !writeLow
      |=> divCount_reg == $past(divCount_reg) + 3'h1)
    else $error("divider ratio wrong");
  a_wrap_flag: assert property (wrapEvent |=> status_reg && count_reg == COUNT_RESET)
    else $error("wrap did not set flag");
  a_snapshot_high: assert property (readLow && wideMode && !writeHigh
      |=> highBuffer_reg == $past(count_reg[15:8]))
    else $error("high byte snapshot missing");
  a_wide_load: assert property (wideLowWriteSeq
      |=> count_reg == {$past(highBuffer_reg), $past(wByte_reg)})
    else $error("wide write did not load both bytes");
  a_div_clear: assert property (writeLow |=> divCount_reg == 3'h0)
    else $error("low write kept divider count");
  a_pins_zero: assert property (runEnable |=> pinReadValue == 2'h0 && pinDirectionOut == 2'h3)
    else $error("pins not forced while running");
  a_osc_off: assert property (!oscEnable |=> !oscOutputPin && !oscOutputEnable)
    else $error("oscillator driven while disabled");

  // ----------------------------------------------------------------
  // Count source and register access assertions
  // ----------------------------------------------------------------
  // Divider must sit at zero, else a 1:1 edge only advances it
  property extStepProp;
    extRiseSeq ##0 (sourceExternal && runEnable && divSelect == 2'h0
      && divCount_reg == 3'h0 && !countWrite) |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty

  property timerStepProp;
    instrTick && !sourceExternal && runEnable && divSelect == 2'h0 && divCount_reg == 3'h0
      && !countWrite |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty

  property timerQuietProp;
    runEnable && !sourceExternal && !instrTick && !countWrite |=> $stable(count_reg);
  endproperty

  property highKeepsDivProp;
    writeHigh && !(runEnable && rawTick) |=> $stable(divCount_reg);
  endproperty

  a_ext_step: assert property (extStepProp)
    else $error("external edge not counted");
  a_timer_step: assert property (timerStepProp)
    else $error("instruction tick not counted");
  a_timer_quiet: assert property (timerQuietProp)
    else $error("timer moved between instruction ticks");
  a_high_div_kept: assert property (highKeepsDivProp)
    else $error("high write disturbed divider");
  a_narrow_high: assert property (writeHigh && !wideMode
      |=> count_reg[15:8] == $past(wByte_reg))
    else $error("narrow high write missed");
  a_buffer_only: assert property (writeHigh && wideMode && !countInc
      |=> $stable(count_reg))
    else $error("wide high write reached the count");

  // ----------------------------------------------------------------
  // Interrupt and pin assertions
  // ----------------------------------------------------------------
  a_status_sticky: assert property (status_reg && !writeStatus |=> status_reg)
    else $error("overflow flag dropped by itself");
  a_status_clear: assert property (statusClearSeq |=> !status_reg)
    else $error("overflow flag not cleared");
  a_irq_masked: assert property (!mask_reg |=> !irq)
    else $error("interrupt raised while masked");
  a_irq_raise: assert property (status_reg && mask_reg |=> irq)
    else $error("interrupt missing");
  a_pins_free: assert property (!runEnable
      |=> pinDirectionOut == $past(portCDirection))
    else $error("pin direction forced while stopped");
endmodule // sixteen_bit_counter

// ### bench/count_source_model.sv
// Model of the external count pin and the low-power crystal
module count_source_model (
  input wire logic go,
  input wire logic useOsc,
  input wire logic [7:0] pulses,
  output logic extPin,
  output logic oscPin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    extPin = 1'b0;
    oscPin = 1'b0;
  end
  // Idle low; half period unrelated to the core clock
  always @(posedge go) begin
    repeat (pulses) begin
      #730;
      if (useOsc) begin
        oscPin = 1'b1;
      end else begin
        extPin = 1'b1;
      end
      #730;
      oscPin = 1'b0;
      extPin = 1'b0;
    end
  end
endmodule // count_source_model

// ### bench/test_sixteen_bit_counter.sv
// Self-checking bench for the sixteen-bit timer/counter
module test_sixteen_bit_counter
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, go, useOsc, sysclkFromOscIn;
  logic awready, wready, bvalid, arready, rvalid, extPin, oscPin, irq;
  logic oscOutputPin, oscOutputEnable;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, portCDirection, oscPinLevel, pinDirectionOut, pinReadValue;
  logic [7:0] pulses;
  int mismatches, n_checks;

  sixteen_bit_counter uut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .externalCountInput(extPin), .oscInputPin(oscPin), .sysclkFromOscIn(sysclkFromOscIn),
    .portCDirection(portCDirection), .oscPinLevel(oscPinLevel), .oscOutputPin(oscOutputPin),
    .oscOutputEnable(oscOutputEnable), .pinDirectionOut(pinDirectionOut),
    .pinReadValue(pinReadValue), .irq(irq));
  count_source_model partner (.go(go), .useOsc(useOsc), .pulses(pulses), .extPin(extPin),
    .oscPin(oscPin));

  // ------------------------------------------------
  // Bus cycles and comparisons
  // ------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_range(input logic [31:0] got, input int lo, input int hi);
    n_checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      mismatches++;
      $display("ERROR at %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // Ready channels stay high, so no answer is ever stalled
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
  endtask
  task automatic rd_reg(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
  endtask
  task automatic pulse(input logic osc, input logic [7:0] n);
    useOsc <= osc;
    pulses <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (n * 16 + 10) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic test_reset_map;
    rd_reg(ADDR_CONTROL);
    check(rd, 32'h00000000);
    rd_reg(5'h14);
    check({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr(5'h14, 8'hFF);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    sysclkFromOscIn <= 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    rd_reg(ADDR_CONTROL);
    check(rd, 32'h00000040);
    sysclkFromOscIn <= 1'b0;
    wr(ADDR_CONTROL, 8'h40);
    rd_reg(ADDR_CONTROL);
    check(rd, 32'h00000000);
  endtask
  task automatic test_timer_div;
    logic [31:0] held;
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_CONTROL, {2'b00, 2'(d), 4'h1});
      repeat (256) @(posedge clk);
      wr(ADDR_CONTROL, 8'h00);
      rd_reg(ADDR_COUNT_LOW);
      check_range(rd, (64 >> d) - 1, (64 >> d) + 2);
    end
    held = rd;
    repeat (40) @(posedge clk);
    rd_reg(ADDR_COUNT_LOW);
    check(rd, held);
  endtask
  task automatic test_external;
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h03);
    pulse(1'b0, 8'd5);
    rd_reg(ADDR_COUNT_LOW);
    check(rd, 32'd5);
    wr(ADDR_CONTROL, 8'h07);
    pulse(1'b0, 8'd3);
    rd_reg(ADDR_COUNT_LOW);
    check(rd, 32'd8);
    wr(ADDR_CONTROL, 8'h0B);
    pulse(1'b0, 8'd4);
    pulse(1'b1, 8'd4);
    rd_reg(ADDR_COUNT_LOW);
    check(rd, 32'd12);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h33);
    pulse(1'b0, 8'd8);
    rd_reg(ADDR_COUNT_LOW);
    check(rd, 32'd1);
    pulse(1'b0, 8'h05);
    wr(ADDR_COUNT_HIGH, 8'h00);
    pulse(1'b0, 8'h03);
    rd_reg(ADDR_COUNT_LOW);
    check(rd, 32'h00000002);
    pulse(1'b0, 8'h05);
    wr(ADDR_COUNT_LOW, 8'h00);
    pulse(1'b0, 8'h03);
    rd_reg(ADDR_COUNT_LOW);
    check(rd, 32'h00000000);
  endtask
  task automatic test_pins;
    portCDirection <= 2'b10;
    oscPinLevel <= 2'b01;
    wr(ADDR_CONTROL, 8'h01);
    repeat (4) @(posedge clk);
    check({28'h0, pinDirectionOut, pinReadValue}, 32'hC);
    wr(ADDR_CONTROL, 8'h08);
    repeat (4) @(posedge clk);
    check({28'h0, pinDirectionOut, pinReadValue}, 32'h9);
    check({31'h0, oscOutputEnable}, 32'h1);
    check({31'h0, oscOutputPin}, 32'h1);
    wr(ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    check({31'h0, oscOutputEnable}, 32'h0);
    check({31'h0, oscOutputPin}, 32'h0);
  endtask
  task automatic test_wide;
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h55);
    rd_reg(ADDR_COUNT_HIGH);
    check(rd, 32'h55);
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_COUNT_HIGH, 8'hAB);
    rd_reg(ADDR_COUNT_HIGH);
    check(rd, 32'hAB);
    wr(ADDR_COUNT_LOW, 8'hCD);
    wr(ADDR_CONTROL, 8'h00);
    rd_reg(ADDR_COUNT_HIGH);
    check(rd, 32'hAB);
    wr(ADDR_COUNT_HIGH, 8'h3C);
    wr(ADDR_CONTROL, 8'h80);
    rd_reg(ADDR_COUNT_HIGH);
    check(rd, 32'hAB);
    rd_reg(ADDR_COUNT_LOW);
    check(rd, 32'hCD);
    rd_reg(ADDR_COUNT_HIGH);
    check(rd, 32'h3C);
  endtask
  task automatic test_overflow(input logic mask);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hFF);
    wr(ADDR_IRQ_MASK, {7'h00, mask});
    wr(ADDR_CONTROL, 8'h03);
    pulse(1'b0, 8'd1);
    rd_reg(ADDR_COUNT_HIGH);
    check(rd, 32'h0);
    rd_reg(ADDR_IRQ_STATUS);
    check(rd, 32'h1);
    check({31'h0, irq}, {31'h0, mask});
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
  endtask

  // ------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run is near 2100 cycles; allow over nine times that
  initial begin
    #2000000;
    mismatches++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, arvalid, go, useOsc, sysclkFromOscIn} = 6'h00;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, wstrb, portCDirection, oscPinLevel, pulses} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_reset_map();
    test_timer_div();
    test_external();
    test_pins();
    test_wide();
    test_overflow(1'b1);
    test_overflow(1'b0);
    give_verdict();
  end
endmodule // test_sixteen_bit_counter
